// ==== include/mpcs_pkg.sv ====
// Package for the motor phase current scale block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package mpcs_pkg;
   localparam int MPCS_ADDR_W = 8;
   localparam int MPCS_DATA_W = 32;
   localparam int MPCS_FIELD_W = 8;
   localparam int MPCS_SCALED_W = 9;
   localparam int MPCS_NUM_PHASES = 4;
   // Register index as printed, byte address is four times it
   localparam logic [MPCS_ADDR_W-1:0] MPCS_SCALE_INDEX = 8'h06;
   localparam logic [MPCS_ADDR_W-1:0] MPCS_SCALE_ADDR = 8'h18;
   localparam logic [MPCS_ADDR_W-1:0] MPCS_CHOP_ADDR = 8'h1C;
   localparam logic [MPCS_ADDR_W-1:0] MPCS_STATUS_ADDR = 8'h20;
   localparam int MPCS_PHASE_A_LSB = 0;
   localparam int MPCS_PHASE_B_LSB = 8;
   localparam int MPCS_PHASE_C_LSB = 16;
   localparam int MPCS_PHASE_D_LSB = 24;
   localparam logic [MPCS_DATA_W-1:0] MPCS_SCALE_RESET = 32'h00000000;
   localparam logic [1:0] MPCS_CHOP_RESET = 2'h0;
   localparam logic [MPCS_SCALED_W-1:0] MPCS_FULL_SCALE = 9'h100;
   localparam logic [MPCS_FIELD_W-1:0] MPCS_MIN_LEGAL = 8'h20;
   localparam logic [MPCS_DATA_W-1:0] MPCS_UNMAPPED_DATA = 32'h00000000;
endpackage

// ==== src/mpcs_phase_mult.sv ====
// Multiplies one phase current demand by its scale factor.
// Assumes the factor comes from a register; output is registered.
`timescale 1ns/100ps
module mpcs_phase_mult
   import mpcs_pkg::*;
#(
   parameter int CUR_W = 9
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [mpcs_pkg::MPCS_FIELD_W-1:0] factor_i,
   input wire logic signed [CUR_W-1:0] demand_i,
   output logic signed [CUR_W-1:0] current_o,
   output logic illegal_o
);
   import mpcs_pkg::*;
   typedef struct packed {
      logic signed [CUR_W-1:0] current;
      logic illegal;
   } mpcs_mult_state_type;
   mpcs_mult_state_type state;
   mpcs_mult_state_type next_state;
   logic [MPCS_SCALED_W-1:0] eff;
   logic signed [CUR_W+MPCS_SCALED_W:0] prod;
   // Refuse widths the scaling cannot serve
   if (CUR_W < 2) begin : g_bad_width
      $error("CUR_W too small");
   end
   always_comb begin
      // Zero means full scale
      eff = (factor_i == 8'h00) ? MPCS_FULL_SCALE : {1'b0, factor_i}; // see (RULE_04)
      prod = demand_i * $signed({1'b0, eff}); // see (RULE_03)
      next_state.current = CUR_W'(prod >>> 8); // see (RULE_05)
      next_state.illegal = (factor_i != 8'h00) && (factor_i < MPCS_MIN_LEGAL);
      if (rst_i) begin
         next_state = '0;
      end
   end
   always_ff @(posedge clk_i) begin
      state <= next_state;
   end
   assign current_o = state.current;
   assign illegal_o = state.illegal;
endmodule

// ==== src/mpcs_scale.sv ====
// Motor phase current scale register and per-phase current scaling.
// Assumes a classic Wishbone master and an external per-phase demand source.
//
// What this block does
// (RULE_01) Bits 7:0 scale phase A and bits 15:8 scale phase B of the first motor.
// (RULE_02) Bits 23:16 scale phase C and bits 31:24 scale phase D of the second motor.
// (RULE_03) Each factor multiplies the demand current of its own phase.
// (RULE_04) A zero field acts as full scale, 256 of 256.
// (RULE_05) Fields 32 to 255 give that value over 256 of maximum current.
// (RULE_06) The host must not write 1 to 31 into any field.
// (RULE_07) Unequal factors within a motor are allowed only in hysteresis chopper mode.
// (RULE_08) The factor also scales chopper hysteresis, so set it before other tuning.
// (RULE_09) The host should prefer values above 128.
// (RULE_10) Reads return the last written word, and reset clears all fields; writes here change only the bytes that sel_i selects.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
module mpcs_scale
   import mpcs_pkg::*;
#(
   parameter int CUR_W = 9,
   parameter int HYST_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [mpcs_pkg::MPCS_ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [mpcs_pkg::MPCS_DATA_W-1:0] dat_i,
   output logic [mpcs_pkg::MPCS_DATA_W-1:0] dat_o,
   output logic ack_o,
   input wire logic [4*CUR_W-1:0] demand_i,
   input wire logic [4*HYST_W-1:0] hyst_i,
   output logic [4*CUR_W-1:0] phase_current_o,
   output logic [4*HYST_W-1:0] phase_hyst_o,
   output logic [1:0] unequal_fault_o
);
   import mpcs_pkg::*;
   typedef struct packed {
      logic [MPCS_DATA_W-1:0] scale;
      logic [1:0] hyst_chop;
      logic ack;
      logic [MPCS_DATA_W-1:0] rdata;
      logic [4*HYST_W-1:0] hyst;
      logic [1:0] fault;
   } mpcs_state_type;
   mpcs_state_type state;
   mpcs_state_type next_state;
   logic [3:0] illegal;
   logic [MPCS_DATA_W-1:0] status_word;
   logic req;
   logic [HYST_W+MPCS_SCALED_W-1:0] hprod;
   logic [MPCS_SCALED_W-1:0] heff;
   // Refuse widths the scaling cannot serve
   if (CUR_W < 2 || HYST_W < 1) begin : g_bad_width
      $error("bad width parameter");
   end
   // Field layout per phase
   genvar g;
   generate
      for (g = 0; g < MPCS_NUM_PHASES; g++) begin : g_phase
         mpcs_phase_mult #(
            .CUR_W(CUR_W)
         ) u_mult (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .factor_i(state.scale[g*MPCS_FIELD_W +: MPCS_FIELD_W]), // see (RULE_01) (RULE_02)
            .demand_i(demand_i[g*CUR_W +: CUR_W]),
            .current_o(phase_current_o[g*CUR_W +: CUR_W]),
            .illegal_o(illegal[g])
         );
      end
   endgenerate
   assign req = cyc_i && stb_i && !state.ack;
   assign status_word = {26'h0000000, state.fault, illegal};
   always_comb begin
      next_state = state;
      next_state.ack = req;
      next_state.rdata = MPCS_UNMAPPED_DATA;
      if (req && !we_i) begin
         if (adr_i == MPCS_SCALE_ADDR) begin
            next_state.rdata = state.scale; // see (RULE_10)
         end else if (adr_i == MPCS_CHOP_ADDR) begin
            next_state.rdata = {30'h00000000, state.hyst_chop};
         end else if (adr_i == MPCS_STATUS_ADDR) begin
            next_state.rdata = status_word;
         end
      end
      if (req && we_i) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b] && adr_i == MPCS_SCALE_ADDR) begin
               next_state.scale[b*8 +: 8] = dat_i[b*8 +: 8]; // see (RULE_10)
            end
         end
         if (sel_i[0] && adr_i == MPCS_CHOP_ADDR) begin
            next_state.hyst_chop = dat_i[1:0];
         end
      end
      // Hysteresis follows the same factor
      for (int p = 0; p < 4; p++) begin
         heff = (state.scale[p*8 +: 8] == 8'h00) ? MPCS_FULL_SCALE
                                                  : {1'b0, state.scale[p*8 +: 8]};
         hprod = hyst_i[p*HYST_W +: HYST_W] * heff; // see (RULE_08)
         next_state.hyst[p*HYST_W +: HYST_W] = hprod[HYST_W+7:8];
      end
      // Unequal motor factors outside hysteresis chopper mode
      for (int m = 0; m < 2; m++) begin
         next_state.fault[m] = !state.hyst_chop[m] &&
            (state.scale[m*16 +: 8] != state.scale[m*16+8 +: 8]); // see (RULE_07)
      end
      if (rst_i) begin
         next_state = '0;
         next_state.scale = MPCS_SCALE_RESET; // see (RULE_10)
         next_state.hyst_chop = MPCS_CHOP_RESET;
      end
   end
   always_ff @(posedge clk_i) begin
      state <= next_state;
   end
   assign ack_o = state.ack;
   assign dat_o = state.rdata;
   assign phase_hyst_o = state.hyst;
   assign unequal_fault_o = state.fault;
endmodule

// ==== verification/mpcs_scale_checker.sv ====
// Bus and scaling checker for the scale block.
// Assumes a bind to the scale block below.
`timescale 1ns/100ps
module mpcs_scale_checker
   import mpcs_pkg::*;
#(parameter int CUR_W = 9) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [mpcs_pkg::MPCS_DATA_W-1:0] dat_o,
   input wire logic ack_o,
   input wire logic [4*CUR_W-1:0] demand_i,
   input wire logic [4*CUR_W-1:0] phase_current_o,
   input wire logic [1:0] unequal_fault_o
);
   wire take = cyc_i && stb_i && !ack_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_next: assert property (take |=> ack_o) else $error("no ack");
   chk_ack_once: assert property (ack_o |=> !ack_o) else $error("long ack");
   chk_ack_cause: assert property (ack_o |-> $past(take)) else $error("stray ack");
   chk_ack_rest: assert property (!cyc_i |=> !ack_o) else $error("idle ack");
   chk_idle_data: assert property (!ack_o |-> dat_o == 0) else $error("idle data");
   chk_full_scale: assert property ($past(rst_i, 2) && !$past(rst_i) |->
      phase_current_o == $past(demand_i)) else $error("full scale");
   chk_fault_clear: assert property ($past(rst_i, 2) && !$past(rst_i) |->
      unequal_fault_o == 2'b00) else $error("fault after reset");
   chk_fault_hold: assert property (!ack_o && !$past(ack_o) |->
      $stable(unequal_fault_o)) else $error("fault moved");
endmodule
bind mpcs_scale mpcs_scale_checker #(.CUR_W(CUR_W)) chk (.clk_i, .rst_i, .cyc_i, .stb_i,
   .dat_o, .ack_o, .demand_i, .phase_current_o, .unequal_fault_o);

// ==== verification/mpcs_scale_test.sv ====
// Self-checking bench for the scale block.
// Assumes the checker binds itself.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected %0t %h", $time, a); end end
module mpcs_scale_test;
   import mpcs_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
   logic [3:0] sel_i = 4'h0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, q, phase_hyst_o, hyst_i = {4{8'hC8}};
   logic [35:0] phase_current_o, demand_i = {4{9'h0C8}};
   logic [1:0] unequal_fault_o;
   int num_errors = 0, checked = 0;
   mpcs_scale dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .demand_i, .hyst_i, .phase_current_o, .phase_hyst_o, .unequal_fault_o);
   initial forever #2.5 clk_i = ~clk_i;
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic t_fields;
      wb(1'b0, MPCS_SCALE_ADDR, 4'hF, 32'h0);
      `CHK(q, 32'h0)
      wb(1'b1, MPCS_SCALE_ADDR, 4'hF, 32'h204080FF);
      `CHK(phase_current_o, {9'h019, 9'h032, 9'h064, 9'h0C7})
      `CHK(phase_hyst_o, 32'h193264C7)
      `CHK(unequal_fault_o, 2'b11)
   endtask
   task automatic t_bytes;
      wb(1'b1, MPCS_SCALE_ADDR, 4'h1, 32'hFFFFFF00);
      wb(1'b1, MPCS_CHOP_ADDR, 4'h1, 32'h1);
      wb(1'b1, 8'h40, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, MPCS_SCALE_ADDR, 4'hF, 32'h0);
      `CHK(q, 32'h20408000)
      `CHK(phase_current_o, {9'h019, 9'h032, 9'h064, 9'h0C8})
      `CHK(unequal_fault_o, 2'b10)
      wb(1'b0, MPCS_CHOP_ADDR, 4'hF, 32'h0);
      `CHK(q, 32'h00000001)
      wb(1'b0, MPCS_STATUS_ADDR, 4'hF, 32'h0);
      `CHK(q, 32'h00000020)
   endtask
   task automatic t_reset;
      wb(1'b1, MPCS_SCALE_ADDR, 4'hF, 32'hC8C8F0F0);
      `CHK(phase_current_o, {9'h09C, 9'h09C, 9'h0BB, 9'h0BB})
      `CHK(phase_hyst_o, 32'h9C9CBBBB)
      `CHK(unequal_fault_o, 2'b00)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, MPCS_SCALE_ADDR, 4'hF, 32'h0);
      `CHK(q, 32'h00000000)
      `CHK(phase_current_o, {4{9'h0C8}})
      wb(1'b0, MPCS_CHOP_ADDR, 4'hF, 32'h0);
      `CHK(q, 32'h00000000)
   endtask
   task automatic results;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_fields;
      t_bytes;
      t_reset;
      results;
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      num_errors++;
      results;
   end
endmodule
